/* File: include/walker_pkg.sv */
// Shared constants and types for the table walker
`default_nettype none
package walker_pkg;
  localparam int          AddrWidth      = 32;
  localparam int          TlbIndexWidth  = 6;
  localparam logic [31:0] TableBaseReset = 32'h0000_0000;
  localparam int          TableBaseLsb   = 14;
  localparam int          SecBaseLsb     = 20;
  localparam int          PtBaseLsb      = 10;
  localparam int          SmallBaseLsb   = 12;
  localparam int          LargeBaseLsb   = 16;
  localparam int          DomainLsb      = 5;
  localparam int          DomainMsb      = 8;
  localparam int          CacheBit       = 3;
  localparam int          BufferBit      = 2;
  localparam int          SecPermLsb     = 10;
  localparam int          SubPermLsb     = 4;
  localparam int          CtrlSystemBit  = 8;
  localparam int          CtrlRomBit     = 9;
  localparam logic [1:0]  DescInvalid    = 2'h0;
  localparam logic [1:0]  DescPageTable  = 2'h1;
  localparam logic [1:0]  DescSection    = 2'h2;
  localparam logic [1:0]  DescLargePage  = 2'h1;
  localparam logic [1:0]  DescSmallPage  = 2'h2;
  localparam logic [1:0]  DomNoAccess    = 2'h0;
  localparam logic [1:0]  DomClient      = 2'h1;
  localparam logic [1:0]  DomManager     = 2'h3;

  typedef enum logic [2:0] {
    WALK_IDLE   = 3'b000,
    WALK_L1REQ  = 3'b001,
    WALK_L1WAIT = 3'b010,
    WALK_L2REQ  = 3'b011,
    WALK_L2WAIT = 3'b100,
    WALK_CHECK  = 3'b101
  } walk_state_t;

  typedef enum logic [1:0] {
    FAULT_NONE    = 2'b00,
    FAULT_SECTION = 2'b01,
    FAULT_PAGE    = 2'b10,
    FAULT_PERM    = 2'b11
  } fault_kind_t;
endpackage
`default_nettype wire

/* File: rtl/access_perm_check.sv */
// Access permission decode for one permission field
`default_nettype none
module access_perm_check (
  input  wire logic [1:0] access_perm_field,
  input  wire logic       systemProt,
  input  wire logic       romProt,
  input  wire logic       isUser,
  input  wire logic       isWrite,
  output logic            permitted
);
  always_comb begin
    permitted = 1'b0;
    // Reserved protection setting overrides every field value
    if (systemProt && romProt) begin
      permitted = 1'b0;
    end else begin
      case (access_perm_field)
        2'h0: begin
          if (systemProt) begin
            permitted = !isUser && !isWrite;
          end else if (romProt) begin
            permitted = !isWrite;
          end else begin
            permitted = 1'b0;
          end
        end
        2'h1: permitted = !isUser;
        2'h2: permitted = !isUser || !isWrite;
        default: permitted = 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/page_table_walker.sv */
// Translation table walker: two-level fetch, decode and permission check
// Notes on behaviour
// - Walk starts only when the lookaside buffer reports a miss.
// - Low 14 bits of the table base read as zero.
// - First fetch word address is base[31:14] joined with vaddr[31:20].
// - First-level type: 00 fault, 01 page table, 10 section, 11 reserved.
// - Reserved first-level type also gives a section translation fault.
// - Page table pointer gives second base [31:10] and domain [8:5].
// - Page table pointer leads to a second fetch before any address.
// - Section bit 3 cacheable, bit 2 bufferable, gated by enables.
// - Section address is desc[31:20] with vaddr[19:0], domain [8:5].
// - Section permission is bits 11:10, read with system and ROM bits.
// - Permission fields apply only in client domains; domain rules first.
// - Permission 00, no protect bits: every access faults.
// - Permission 00, system only: supervisor reads only.
// - Permission 00, ROM only: reads in both modes, writes fault.
// - Permission 01: supervisor read/write, user faults.
// - Permission 10: supervisor read/write, user read only.
// - Permission 11: everything allowed unless system and ROM bits are both set.
// - Permission check finishes before the physical address is driven.
// - Second-level type: 00 fault, 01 large, 10 small, 11 reserved.
// - Reserved second-level type also gives a page translation fault.
// - Second-level bit 2 bufferable, bit 3 cacheable.
// - Four sub-page permission fields in bits 11:4, top field highest.
// - Page number from [31:12] small or [31:16] large, rest virtual.
// - Successful walk writes the buffer, victim chosen round robin.
`default_nettype none
module page_table_walker
  import walker_pkg::*;
(
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  input  wire logic                               tableBaseWrite,
  input  wire logic [31:0]                        tableBaseData,
  input  wire logic [31:0]                        controlReg,
  input  wire logic [31:0]                        domainCtrl,
  input  wire logic                               reqValid,
  input  wire logic [walker_pkg::AddrWidth-1:0]   reqVaddr,
  input  wire logic                               reqWrite,
  input  wire logic                               reqUser,
  input  wire logic                               tlbHit,
  input  wire logic                               cacheEnable,
  input  wire logic                               bufferEnable,
  output logic                                    memReadValid,
  output logic [29:0]                             memWordAddr,
  input  wire logic                               memReadDone,
  input  wire logic [31:0]                        memReadData,
  output logic                                    walkDone,
  output logic [1:0]                              walkFault,
  output logic [3:0]                              walkDomain,
  output logic [walker_pkg::AddrWidth-1:0]        physAddr,
  output logic                                    physCacheable,
  output logic                                    physBufferable,
  output logic                                    tlbWrite,
  output logic [walker_pkg::TlbIndexWidth-1:0]    tlbWriteIndex,
  output logic                                    walkBusy
);
  import walker_pkg::*;

  typedef struct packed {
    walk_state_t               state;
    logic [31:0]               tableBase;
    logic [31:0]               vaddr;
    logic                      isWrite;
    logic                      isUser;
    logic [31:0]               desc;
    logic [3:0]                domain;
    logic                      isPage;
    logic                      isLarge;
    logic [29:0]               memAddr;
    logic                      done;
    fault_kind_t               fault;
    logic [31:0]               pa;
    logic                      cacheable;
    logic                      bufferable;
    logic                      tlbWr;
    logic [TlbIndexWidth-1:0]  victim;
    logic [TlbIndexWidth-1:0]  wrIndex;
  } walk_regs_t;

  walk_regs_t regs_q;
  walk_regs_t regs_d;

  logic [1:0] permField;
  logic [1:0] domainMode;
  logic       permOk;
  logic [1:0] subSel;

  // Permission field of the descriptor currently held
  always_comb begin
    subSel = regs_q.isLarge ? regs_q.vaddr[15:14] : regs_q.vaddr[11:10];
    if (regs_q.isPage) begin
      permField = regs_q.desc[SubPermLsb + 2*subSel +: 2];
    end else begin
      permField = regs_q.desc[SecPermLsb +: 2];
    end
    domainMode = domainCtrl[2*regs_q.domain +: 2];
  end

  access_perm_check permCheck (
    .access_perm_field (permField),
    .systemProt        (controlReg[CtrlSystemBit]),
    .romProt           (controlReg[CtrlRomBit]),
    .isUser            (regs_q.isUser),
    .isWrite           (regs_q.isWrite),
    .permitted         (permOk)
  );

  always_comb begin
    regs_d = regs_q;
    regs_d.done = 1'b0;
    regs_d.tlbWr = 1'b0;
    if (tableBaseWrite) begin
      regs_d.tableBase = {tableBaseData[31:TableBaseLsb],
                          {TableBaseLsb{1'b0}}};
    end
    case (regs_q.state)
      WALK_IDLE: begin
        if (reqValid && !tlbHit) begin
          regs_d.vaddr = reqVaddr;
          regs_d.isWrite = reqWrite;
          regs_d.isUser = reqUser;
          regs_d.isPage = 1'b0;
          regs_d.isLarge = 1'b0;
          regs_d.memAddr = {regs_q.tableBase[31:TableBaseLsb],
                            reqVaddr[31:SecBaseLsb]};
          regs_d.state = WALK_L1REQ;
        end
      end
      WALK_L1REQ: begin
        regs_d.state = WALK_L1WAIT;
      end
      WALK_L1WAIT: begin
        if (memReadDone) begin
          regs_d.desc = memReadData;
          regs_d.domain = memReadData[DomainMsb:DomainLsb];
          case (memReadData[1:0])
            DescPageTable: begin
              regs_d.isPage = 1'b1;
              regs_d.memAddr = {memReadData[31:PtBaseLsb],
                                regs_q.vaddr[19:12]};
              regs_d.state = WALK_L2REQ;
            end
            DescSection: begin
              regs_d.state = WALK_CHECK;
            end
            default: begin
              regs_d.fault = FAULT_SECTION;
              regs_d.done = 1'b1;
              regs_d.state = WALK_IDLE;
            end
          endcase
        end
      end
      WALK_L2REQ: begin
        regs_d.state = WALK_L2WAIT;
      end
      WALK_L2WAIT: begin
        if (memReadDone) begin
          regs_d.desc = memReadData;
          case (memReadData[1:0])
            DescLargePage: begin
              regs_d.isLarge = 1'b1;
              regs_d.state = WALK_CHECK;
            end
            DescSmallPage: begin
              regs_d.isLarge = 1'b0;
              regs_d.state = WALK_CHECK;
            end
            default: begin
              regs_d.fault = FAULT_PAGE;
              regs_d.done = 1'b1;
              regs_d.state = WALK_IDLE;
            end
          endcase
        end
      end
      WALK_CHECK: begin
        regs_d.done = 1'b1;
        regs_d.state = WALK_IDLE;
        if (domainMode == DomManager ||
            (domainMode == DomClient && permOk)) begin
          regs_d.fault = FAULT_NONE;
          if (!regs_q.isPage) begin
            regs_d.pa = {regs_q.desc[31:SecBaseLsb],
                         regs_q.vaddr[SecBaseLsb-1:0]};
          end else if (regs_q.isLarge) begin
            regs_d.pa = {regs_q.desc[31:LargeBaseLsb],
                         regs_q.vaddr[LargeBaseLsb-1:0]};
          end else begin
            regs_d.pa = {regs_q.desc[31:SmallBaseLsb],
                         regs_q.vaddr[SmallBaseLsb-1:0]};
          end
          regs_d.cacheable = regs_q.desc[CacheBit] && cacheEnable;
          regs_d.bufferable = regs_q.desc[BufferBit] && bufferEnable;
          regs_d.tlbWr = 1'b1;
          regs_d.wrIndex = regs_q.victim;
          regs_d.victim = regs_q.victim + 1'b1;
        end else begin
          // Domain faults are reported through the permission code here
          regs_d.fault = FAULT_PERM;
        end
      end
      default: begin
        regs_d.state = WALK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regs_q <= '0;
      regs_q.state <= WALK_IDLE;
      regs_q.tableBase <= TableBaseReset;
      regs_q.fault <= FAULT_NONE;
    end else begin
      regs_q <= regs_d;
    end
  end

  assign memReadValid   = (regs_q.state == WALK_L1REQ) ||
                          (regs_q.state == WALK_L2REQ);
  assign memWordAddr    = regs_q.memAddr;
  assign walkDone       = regs_q.done;
  assign walkFault      = regs_q.fault;
  assign walkDomain     = regs_q.domain;
  assign physAddr       = regs_q.pa;
  assign physCacheable  = regs_q.cacheable;
  assign physBufferable = regs_q.bufferable;
  assign tlbWrite       = regs_q.tlbWr;
  assign tlbWriteIndex  = regs_q.wrIndex;
  assign walkBusy       = regs_q.state != WALK_IDLE;

  a_hit_no_walk: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_IDLE && reqValid && tlbHit
      |=> regs_q.state == WALK_IDLE)
    else $error("walk started on hit");
  a_base_aligned: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.tableBase[13:0] == 14'h0000)
    else $error("table base not aligned");
  a_l1_address: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L1REQ |-> memWordAddr ==
      {regs_q.tableBase[31:14], regs_q.vaddr[31:20]})
    else $error("bad first level address");
  a_sec_fault: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L1WAIT && memReadDone && (memReadData[1:0] == 2'h0
      || memReadData[1:0] == 2'h3)
      |=> walkDone && walkFault == FAULT_SECTION)
    else $error("missing section fault");
  a_l2_follows: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L1WAIT && memReadDone && memReadData[1:0] == 2'h1
      |=> !walkDone && memReadValid &&
        memWordAddr == {regs_q.desc[31:10], regs_q.vaddr[19:12]})
    else $error("second fetch not issued");
  a_page_fault: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L2WAIT && memReadDone && (memReadData[1:0] == 2'h0
      || memReadData[1:0] == 2'h3)
      |=> walkDone && walkFault == FAULT_PAGE)
    else $error("missing page fault");
  a_perm_fault: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && domainMode == DomClient && !permOk
      |=> walkFault == FAULT_PERM && !tlbWrite)
    else $error("permission fault missed");
  a_victim_step: assert property (@(posedge clk_sys) disable iff (rst)
    tlbWrite ##1 (!tlbWrite)[*1] ##[0:20] tlbWrite
      |-> tlbWriteIndex == $past(regs_q.victim) &&
        regs_q.victim == tlbWriteIndex + 1'b1)
    else $error("victim index wrong");
  a_section_pa: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && !regs_q.isPage
      ##1 tlbWrite |-> physAddr[19:0] == $past(regs_q.vaddr[19:0])
        && physAddr[31:20] == regs_q.desc[31:20])
    else $error("section offset not passed");

  // Fetch sequencing and descriptor decode
  a_take_fetch: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_IDLE && reqValid && !tlbHit
      |=> memReadValid && walkBusy)
    else $error("miss did not start a fetch");
  a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
    walkBusy && reqValid |=> $stable(regs_q.vaddr))
    else $error("request taken while busy");
  a_fetch_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    memReadValid |=> !memReadValid)
    else $error("fetch request longer than a cycle");
  a_l2_address: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L2REQ |-> memWordAddr ==
      {regs_q.desc[31:10], regs_q.vaddr[19:12]})
    else $error("bad second level address");
  a_domain_load: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L1WAIT && memReadDone
      |=> walkDomain == $past(memReadData[8:5]))
    else $error("domain not taken from first descriptor");
  a_base_load: assert property (@(posedge clk_sys) disable iff (rst)
    tableBaseWrite
      |=> regs_q.tableBase[31:14] == $past(tableBaseData[31:14]))
    else $error("table base not loaded");
  a_sec_decode: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L1WAIT && memReadDone && memReadData[1:0] == 2'h2
      |=> regs_q.state == WALK_CHECK && !regs_q.isPage)
    else $error("section descriptor not checked");
  a_page_decode: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L2WAIT && memReadDone && (memReadData[1:0] == 2'h1
      || memReadData[1:0] == 2'h2)
      |=> regs_q.state == WALK_CHECK &&
        regs_q.isLarge == ($past(memReadData[1:0]) == 2'h1))
    else $error("page size decoded wrongly");
  a_l2_no_fill: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_L2REQ || regs_q.state == WALK_L2WAIT
      |-> !walkDone && !tlbWrite)
    else $error("result before second fetch");

  // Domain, permission and result checks
  a_manager_ok: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && domainMode == DomManager
      |=> walkDone && walkFault == FAULT_NONE && tlbWrite)
    else $error("manager domain faulted");
  a_domain_deny: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && domainMode != DomManager
      && domainMode != DomClient |=> walkFault == FAULT_PERM)
    else $error("closed domain not faulted");
  a_perm_pass: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && domainMode == DomClient && permOk
      |=> walkFault == FAULT_NONE && tlbWrite)
    else $error("permitted access faulted");
  a_sysrom_deny: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && domainMode == DomClient
      && controlReg[CtrlRomBit] && controlReg[CtrlSystemBit]
      |=> walkFault == FAULT_PERM && !tlbWrite)
    else $error("reserved protection setting granted access");
  a_fault_nofill: assert property (@(posedge clk_sys) disable iff (rst)
    walkDone && walkFault != FAULT_NONE |-> !tlbWrite && $stable(physAddr))
    else $error("address produced on a fault");
  a_large_pa: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && regs_q.isPage && regs_q.isLarge
      ##1 tlbWrite |-> physAddr ==
        {regs_q.desc[31:16], regs_q.vaddr[15:0]})
    else $error("large page address wrong");
  a_small_pa: assert property (@(posedge clk_sys) disable iff (rst)
    regs_q.state == WALK_CHECK && regs_q.isPage && !regs_q.isLarge
      ##1 tlbWrite |-> physAddr ==
        {regs_q.desc[31:12], regs_q.vaddr[11:0]})
    else $error("small page address wrong");
  a_attr_gated: assert property (@(posedge clk_sys) disable iff (rst)
    tlbWrite |-> physCacheable == (regs_q.desc[3] && $past(cacheEnable))
      && physBufferable == (regs_q.desc[2] && $past(bufferEnable)))
    else $error("attribute not gated by enable");
  a_fill_done: assert property (@(posedge clk_sys) disable iff (rst)
    tlbWrite |-> walkDone && walkFault == FAULT_NONE)
    else $error("fill outside a successful walk");
endmodule
`default_nettype wire

/* File: tb/mem_model.sv */
// Physical memory model answering descriptor fetches
`default_nettype none
module mem_model (
  input  wire logic        clk_sys,
  input  wire logic        memReadValid,
  input  wire logic [29:0] memWordAddr,
  output logic             memReadDone,
  output logic [31:0]      memReadData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [29:0]];
  logic [29:0] addr;
  int          lag = 0;
  int          cnt = -1;
  initial begin
    memReadDone = 1'b0;
    memReadData = 32'h0;
  end
  // Idle data bus flips every cycle; absent words read as invalid
  always @(negedge clk_sys) begin
    if (cnt == 0 && !memReadValid) begin
      memReadDone <= 1'b1;
      memReadData <= mem.exists(addr) ? mem[addr] : 32'h0;
      cnt = -1;
    end else begin
      memReadDone <= 1'b0;
      memReadData <= ~memReadData;
      if (memReadValid) begin
        addr = memWordAddr;
        cnt = lag;
      end else if (cnt > 0) begin
        cnt--;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the table walker
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import walker_pkg::*;
  typedef struct {
    logic [1:0] f; logic [31:0] pa; logic [3:0] dom; logic c, b, pg;
  } exp_t;
  logic clk_sys = 0, rst = 1, tableBaseWrite = 0, reqValid = 0;
  logic reqWrite = 0, reqUser = 0, tlbHit = 0;
  logic cacheEnable = 0, bufferEnable = 0;
  logic [31:0] tableBaseData = 0, controlReg = 0, domainCtrl = 0;
  logic [31:0] reqVaddr = 0, base = 0, rng = 32'd11073;
  logic memReadValid, memReadDone, walkDone, physCacheable, physBufferable;
  logic tlbWrite, walkBusy;
  logic [29:0] memWordAddr;
  logic [31:0] memReadData, physAddr;
  logic [1:0] walkFault;
  logic [3:0] walkDomain;
  logic [5:0] tlbWriteIndex;
  int mismatches = 0, n_tests = 0, fills = 0, fetches = 0;
  exp_t q[$];

  page_table_walker i_dut (.clk_sys(clk_sys), .rst(rst),
    .tableBaseWrite(tableBaseWrite), .tableBaseData(tableBaseData),
    .controlReg(controlReg), .domainCtrl(domainCtrl),
    .reqValid(reqValid), .reqVaddr(reqVaddr), .reqWrite(reqWrite),
    .reqUser(reqUser), .tlbHit(tlbHit), .cacheEnable(cacheEnable),
    .bufferEnable(bufferEnable), .memReadValid(memReadValid),
    .memWordAddr(memWordAddr), .memReadDone(memReadDone),
    .memReadData(memReadData), .walkDone(walkDone), .walkFault(walkFault),
    .walkDomain(walkDomain), .physAddr(physAddr),
    .physCacheable(physCacheable), .physBufferable(physBufferable),
    .tlbWrite(tlbWrite), .tlbWriteIndex(tlbWriteIndex),
    .walkBusy(walkBusy));
  mem_model i_mem (.clk_sys(clk_sys), .memReadValid(memReadValid),
    .memWordAddr(memWordAddr), .memReadDone(memReadDone),
    .memReadData(memReadData));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic permOk(logic [1:0] ap, logic s, r, u, w);
    if (s && r) return 1'b0;
    case (ap)
      2'h0: return s ? (!u && !w) : (r && !w);
      2'h1: return !u;
      2'h2: return !u || !w;
      default: return 1'b1;
    endcase
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic run(logic [31:0] d1, d2, va, logic u, w);
    exp_t e;
    logic [1:0] mode, ap;
    logic [31:0] d;
    i_mem.mem.delete();
    i_mem.mem[{base[31:14], va[31:20]}] = d1;
    e.pg = d1[1:0] == DescPageTable;
    if (e.pg) i_mem.mem[{d1[31:10], va[19:12]}] = d2;
    d = e.pg ? d2 : d1;
    e.dom = d1[8:5];
    mode = domainCtrl[2*d1[8:5] +: 2];
    e.c = d[3] & cacheEnable;
    e.b = d[2] & bufferEnable;
    if (!e.pg) begin
      e.pa = {d1[31:20], va[19:0]};
      ap = d1[11:10];
    end else if (d2[1:0] == DescSmallPage) begin
      e.pa = {d2[31:12], va[11:0]};
      ap = d2[4+2*va[11:10] +: 2];
    end else begin
      e.pa = {d2[31:16], va[15:0]};
      ap = d2[4+2*va[15:14] +: 2];
    end
    if (d1[1:0] == 2'h0 || d1[1:0] == 2'h3) e.f = FAULT_SECTION;
    else if (e.pg && (d2[1:0] == 2'h0 || d2[1:0] == 2'h3)) e.f = FAULT_PAGE;
    else if (mode == DomNoAccess || mode == 2'h2) e.f = FAULT_PERM;
    else if (mode == DomClient
             && !permOk(ap, controlReg[8], controlReg[9], u, w))
      e.f = FAULT_PERM;
    else e.f = FAULT_NONE;
    q.push_back(e);
    @(negedge clk_sys);
    {reqVaddr, reqUser, reqWrite, reqValid} = {va, u, w, 1'b1};
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (int i = 0; i < 60 && walkBusy !== 1'b0; i++) @(negedge clk_sys);
    if (walkBusy !== 1'b0) begin
      mismatches++;
      print_verdict();
    end
  endtask

  always @(negedge clk_sys) begin
    exp_t e;
    if (memReadValid === 1'b1) fetches++;
    if (walkDone === 1'b1) begin
      if (q.size() == 0) check("spare done", 32'h1, 32'h0);
      else begin
        e = q.pop_front();
        check("fault", walkFault, e.f);
        check("fetches", 32'(fetches), (e.pg && e.f != FAULT_SECTION) ? 2 : 1);
        if (e.f != FAULT_SECTION) check("domain", walkDomain, e.dom);
        check("fill", tlbWrite, e.f == FAULT_NONE);
        if (e.f == FAULT_NONE) begin
          check("phys", physAddr, e.pa);
          check("attr", {physCacheable, physBufferable}, {e.c, e.b});
          check("victim", tlbWriteIndex, fills[5:0]);
          fills++;
        end
      end
      fetches = 0;
    end
  end

  initial begin
    #2_000_000;
    mismatches++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    tableBaseData = rnd();
    base = tableBaseData & 32'hFFFF_C000;
    tableBaseWrite = 1'b1;
    @(negedge clk_sys);
    tableBaseWrite = 1'b0;
    domainCtrl = 32'h5555_5555;
    // Every permission, protection, privilege and direction mix on sections
    for (int k = 0; k < 64; k++) begin
      r = rnd();
      {cacheEnable, bufferEnable} = r[1:0];
      controlReg = {22'h0, k[3:2], 8'h00};
      i_mem.lag = k % 3;
      run({r[31:20], 8'h00, k[1:0], 1'b0, r[8:5], 1'b1, r[3:2], 2'h2},
          32'h0, rnd(), k[4], k[5]);
    end
    // All descriptor types, domain modes and page sizes
    for (int k = 0; k < 96; k++) begin
      r = rnd();
      {cacheEnable, bufferEnable} = r[1:0];
      controlReg = {22'h0, r[3:2], 8'h00};
      domainCtrl = rnd();
      i_mem.lag = k % 4;
      run({rnd()}, {rnd()}, rnd(), r[4], r[5]);
      run({r[31:10], 1'b0, r[8:5], 1'b1, r[3:2], 2'(k[1:0] + 2'h1)},
          {rnd()} & ~32'h3 | 32'(k[3:2]), rnd(), r[6], r[7]);
    end
    // Hit in the lookaside buffer starts no walk
    tlbHit = 1'b1;
    reqValid = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("busy on hit", walkBusy, 32'h0);
    check("fetch on hit", 32'(fetches), 32'h0);
    {tlbHit, reqValid} = 2'b00;
    repeat (2) @(negedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire
